// ### verilog/phytx_ctrl.sv
// Function
// - INT_N low while any latched condition and its mask bit are both one.
// - Reset clears the whole interrupt mask register.
// - Mask bits 0..7 gate the eight condition flags in fixed order.
// - Mode 000 passes request data; mode 001 sends Idle pairs.
// - Mode 010 sends Quiet pairs and drops the transmitter enable.
// - Reserved modes 011 and 111 send Quiet pairs.
// - Mode 100 sends Master pairs.
// - Mode 101 sends Halt pairs; mode 110 sends Quiet pairs.
// - Injection beats mode symbols; mode symbols beat request data.
// - Reset loads Off mode, smoother on, top bit one, rest zero.
// - Trigger copies preset mode; writes then rejected and flagged.
// - In Stop mode the mode and inject fields have no effect; smoother and parity bits still drive their outputs.
// - Field layout: mode 0-2, inject 3-4, smoother 5, parity 6, top 7.
// - Mask at 03h always read/write; state at 04h conditional write.
// - Bits changed since last read keep value; inhibit flag raised.
// - One-shot injection done clears the low injection bit itself.
`timescale 1ns/1ps
`default_nettype none
`include "phytx_consts.svh"

module phytx_ctrl
  import phytx_pkg::*;
#(
  parameter int PAIR_W = 10
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              CB_STB,
  input  wire logic              CB_WE,
  input  wire logic [7:0]        CB_ADDR,
  input  wire logic [7:0]        CB_WDATA,
  output logic      [7:0]        CB_RDATA,
  input  wire logic [7:0]        INT_COND,
  output logic                   INT_N,
  output logic                   WREJ_SET,
  output logic                   CWI_SET,
  input  wire logic              TRIG_FIRE,
  input  wire logic [2:0]        TRIG_MODE,
  input  wire logic              STOP_MODE,
  input  wire logic [PAIR_W-1:0] REQ_PAIR,
  input  wire logic              REQ_VALID,
  output logic                   REQ_READY,
  input  wire logic [PAIR_W-1:0] INJ_PAIR,
  input  wire logic              INJ_HIT,
  output logic                   INJ_DONE,
  output logic      [PAIR_W-1:0] TX_PAIR,
  output logic                   TX_VALID,
  input  wire logic              TX_READY,
  output logic                   TX_ENABLE,
  output logic                   SMOOTH_EN,
  output logic                   PARITY_EN
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0]        irq_mask_r;
  logic [7:0]        tsc_r;
  logic [7:0]        tsc_nxt;
  logic [7:0]        cmp_r;
  logic [7:0]        hold_bits;
  logic              wr_mask;
  logic              wr_tsc;
  logic              rd_tsc;
  logic              wr_blocked;
  logic [PAIR_W-1:0] buf_data;
  logic              buf_valid;
  logic              buf_ready;
  logic              load;
  logic              gen_ok;
  logic              inject;
  logic              once_done;
  phytx_mode_t       mode_sel;
  phytx_mode_t       mode_act_r;
  phytx_inj_t        inj_mode;

  // Mode symbols per code
  function automatic logic [PAIR_W-1:0] mode_pair(
    input phytx_mode_t m
  );
    logic [PAIR_W-1:0] p;
    p = PAIR_W'(`PHYTX_PAIR_QUIET);
    unique case (m)
      PHYTX_IDLE:   p = PAIR_W'(`PHYTX_PAIR_IDLE);
      PHYTX_MASTER: p = PAIR_W'(`PHYTX_PAIR_MAST);
      PHYTX_HALT:   p = PAIR_W'(`PHYTX_PAIR_HALT);
      PHYTX_ACTIVE,
      PHYTX_OFF,
      PHYTX_RSV3,
      PHYTX_QUIET,
      PHYTX_RSV7:   p = PAIR_W'(`PHYTX_PAIR_QUIET);
    endcase
    return p;
  endfunction

  // ****************************************
  // Control bus decode
  // ****************************************
  assign wr_mask = CB_STB && CB_WE && (CB_ADDR == `PHYTX_ADDR_MASK);
  assign wr_tsc  = CB_STB && CB_WE && (CB_ADDR == `PHYTX_ADDR_TSC);
  assign rd_tsc  = CB_STB && !CB_WE && (CB_ADDR == `PHYTX_ADDR_TSC);
  assign wr_blocked = wr_tsc && TRIG_FIRE;
  assign hold_bits = tsc_r ^ cmp_r;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CB_RDATA <= `PHYTX_RD_IDLE;
    end else if (CB_STB && !CB_WE) begin
      unique case (CB_ADDR)
        `PHYTX_ADDR_MASK: CB_RDATA <= irq_mask_r;
        `PHYTX_ADDR_TSC:  CB_RDATA <= tsc_r;
        `PHYTX_ADDR_CMP:  CB_RDATA <= cmp_r;
        default:          CB_RDATA <= `PHYTX_RD_IDLE;
      endcase
    end
  end

  // ****************************************
  // Interrupt mask and pin
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_mask_r <= `PHYTX_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_r <= CB_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      INT_N <= 1'b1;
    end else begin
      INT_N <= ~|(INT_COND & irq_mask_r);
    end
  end

  // ****************************************
  // Transmit state register
  // ****************************************
  assign inj_mode  = phytx_inj_t'(tsc_r[`PHYTX_IC_HIGH:`PHYTX_IC_LOW]);
  assign once_done = load && inject && (inj_mode == PHYTX_INJ_ONCE);

  always_comb begin
    tsc_nxt = tsc_r;
    if (TRIG_FIRE) begin
      tsc_nxt[`PHYTX_TM_HI:`PHYTX_TM_LO] = TRIG_MODE;
    end else if (wr_tsc) begin
      tsc_nxt = (tsc_r & hold_bits) | (CB_WDATA & ~hold_bits);
    end
    if (once_done) begin
      tsc_nxt[`PHYTX_IC_LOW] = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // off, smoother on, top bit set
      tsc_r <= `PHYTX_TSC_RST;
    end else begin
      tsc_r <= tsc_nxt;
    end
  end

  // Compare copy follows each read
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmp_r <= `PHYTX_TSC_RST;
    end else if (rd_tsc) begin
      cmp_r <= tsc_r;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WREJ_SET <= 1'b0;
      CWI_SET  <= 1'b0;
    end else begin
      WREJ_SET <= wr_blocked;
      CWI_SET  <= wr_tsc && !TRIG_FIRE && (hold_bits != 8'h00);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SMOOTH_EN <= 1'(`PHYTX_TSC_RST >> `PHYTX_SMOOTH);
      PARITY_EN <= 1'b0;
    end else begin
      SMOOTH_EN <= tsc_nxt[`PHYTX_SMOOTH];
      PARITY_EN <= tsc_nxt[`PHYTX_PAR_EN];
    end
  end

  // ****************************************
  // Request data buffer
  // ****************************************
  phytx_buf #(
    .W (PAIR_W)
  ) u_buf (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .in_data   (REQ_PAIR),
    .in_valid  (REQ_VALID),
    .in_ready  (REQ_READY),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready)
  );

  // ****************************************
  // Output selection
  // ****************************************
  // stop forces quiet regardless
  assign mode_sel = STOP_MODE ? PHYTX_OFF :
                    phytx_mode_t'(tsc_r[`PHYTX_TM_HI:`PHYTX_TM_LO]);
  assign inject   = !STOP_MODE && (inj_mode != PHYTX_INJ_NONE) &&
                    ((inj_mode == PHYTX_INJ_CONT) || INJ_HIT);
  // Generated pairs never wait on request data
  assign gen_ok   = inject || (mode_sel != PHYTX_ACTIVE) || buf_valid;
  assign load     = (!TX_VALID || TX_READY) && gen_ok;
  // Non-active modes still drain data so the source never wedges
  assign buf_ready = (!TX_VALID || TX_READY);

  // whole pair per beat, mode sampled at load
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_PAIR    <= PAIR_W'(`PHYTX_PAIR_QUIET);
      TX_VALID   <= 1'b0;
      mode_act_r <= PHYTX_OFF;
    end else if (load) begin
      TX_VALID   <= 1'b1;
      mode_act_r <= mode_sel;
      // injection first, then mode, then data
      if (inject) begin
        TX_PAIR <= INJ_PAIR;
      end else if (mode_sel == PHYTX_ACTIVE) begin
        TX_PAIR <= buf_data;
      end else begin
        TX_PAIR <= mode_pair(mode_sel);
      end
    end else if (TX_READY) begin
      TX_VALID <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_ENABLE <= 1'b0;
      INJ_DONE  <= 1'b0;
    end else begin
      // enable dropped only in off mode
      TX_ENABLE <= (load ? mode_sel : mode_act_r) != PHYTX_OFF;
      INJ_DONE  <= once_done;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  irq_pin_a: assert property (
    |(INT_COND & irq_mask_r) |=> !INT_N
  ) else $error("interrupt not asserted");

  irq_release_a: assert property (
    (INT_COND & irq_mask_r) == 8'h00 |=> INT_N
  ) else $error("interrupt stuck low");

  mask_write_a: assert property (
    wr_mask |=> irq_mask_r == $past(CB_WDATA)
  ) else $error("mask write lost");

  idle_pair_a: assert property (
    load && !inject && mode_sel == PHYTX_IDLE
      |=> TX_PAIR == PAIR_W'(`PHYTX_PAIR_IDLE)
  ) else $error("idle pair wrong");

  master_pair_a: assert property (
    load && !inject && mode_sel == PHYTX_MASTER
      |=> TX_PAIR == PAIR_W'(`PHYTX_PAIR_MAST)
  ) else $error("master pair wrong");

  off_txe_a: assert property (
    load && mode_sel == PHYTX_OFF
      |=> !TX_ENABLE &&
          (TX_PAIR == PAIR_W'(`PHYTX_PAIR_QUIET) || $past(inject))
  ) else $error("off mode wrong");

  inject_prio_a: assert property (
    load && inject |=> TX_PAIR == $past(INJ_PAIR)
  ) else $error("injection lost priority");

  trig_copy_a: assert property (
    TRIG_FIRE && wr_tsc
      |=> WREJ_SET &&
          tsc_r[`PHYTX_TM_HI:`PHYTX_TM_LO] == $past(TRIG_MODE)
  ) else $error("trigger copy or reject wrong");

  cond_hold_a: assert property (
    wr_tsc && !TRIG_FIRE && !once_done
      |=> ((tsc_r ^ $past(tsc_r)) & $past(hold_bits)) == 8'h00
  ) else $error("changed bit overwritten");

  oneshot_clr_a: assert property (
    once_done |=> !tsc_r[`PHYTX_IC_LOW] ##0 INJ_DONE
  ) else $error("one-shot not cleared");

  stall_hold_a: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_PAIR)
  ) else $error("pair changed under stall");

  trig_c:   cover property (TRIG_FIRE && wr_tsc);
  inhib_c:  cover property (CWI_SET);
  once_c:   cover property (once_done);
  stall_c:  cover property (!REQ_READY ##1 REQ_READY);

endmodule // phytx_ctrl

`default_nettype wire

// ### inc/phytx_consts.svh
`ifndef PHYTX_CONSTS_SVH
`define PHYTX_CONSTS_SVH

// ****************************************
// Control bus addresses
// ****************************************
`define PHYTX_ADDR_MASK  8'h03
`define PHYTX_ADDR_TSC   8'h04
`define PHYTX_ADDR_CMP   8'h1B

// ****************************************
// Reset values
// ****************************************
`define PHYTX_MASK_RST   8'h00
`define PHYTX_TSC_RST    8'hA2
`define PHYTX_RD_IDLE    8'h00

// ****************************************
// Transmit state field positions
// ****************************************
`define PHYTX_TM_LO      0
`define PHYTX_TM_HI      2
`define PHYTX_IC_LOW     3
`define PHYTX_IC_HIGH    4
`define PHYTX_SMOOTH     5
`define PHYTX_PAR_EN     6

// ****************************************
// Mask bit positions
// ****************************************
`define PHYTX_WREJ_BIT   2
`define PHYTX_CWI_BIT    3

// ****************************************
// Symbol pairs
// ****************************************
`define PHYTX_PAIR_IDLE  10'h3FF
`define PHYTX_PAIR_QUIET 10'h000
`define PHYTX_PAIR_MAST  10'h080
`define PHYTX_PAIR_HALT  10'h084

`endif

// ### inc/phytx_pkg.sv
package phytx_pkg;

  typedef enum logic [2:0] {
    PHYTX_ACTIVE = 3'b000,
    PHYTX_IDLE   = 3'b001,
    PHYTX_OFF    = 3'b010,
    PHYTX_RSV3   = 3'b011,
    PHYTX_MASTER = 3'b100,
    PHYTX_HALT   = 3'b101,
    PHYTX_QUIET  = 3'b110,
    PHYTX_RSV7   = 3'b111
  } phytx_mode_t;

  typedef enum logic [1:0] {
    PHYTX_INJ_NONE   = 2'b00,
    PHYTX_INJ_ONCE   = 2'b01,
    PHYTX_INJ_PERIOD = 2'b10,
    PHYTX_INJ_CONT   = 2'b11
  } phytx_inj_t;

endpackage : phytx_pkg

// ### verilog/phytx_buf.sv
`timescale 1ns/1ps
`default_nettype none

module phytx_buf #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rp_r];
  assign out_valid = (cnt_r != 2'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'h0;
      in_ready <= 1'b1;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      // Ready from a flop: full whenever two held, even in a cycle where one leaves
      unique case ({push, pop})
        2'b10: begin
          cnt_r    <= cnt_r + 2'h1;
          in_ready <= (cnt_r == 2'h0);
        end
        2'b01: begin
          cnt_r    <= cnt_r - 2'h1;
          in_ready <= 1'b1;
        end
        default: begin
          cnt_r    <= cnt_r;
          in_ready <= in_ready;
        end
      endcase
    end
  end

endmodule // phytx_buf

`default_nettype wire

// ### testbench/phytx_pmd_model.sv
`timescale 1ns/1ps
`default_nettype none

module phytx_pmd_model #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] tx_pair,
  input  wire logic         tx_valid,
  output logic              tx_ready,
  input  wire logic         stall,
  input  wire logic         slow,
  output logic [W-1:0]      last_pair,
  output int                beats
);
  int seed = 15745;

  // ****************************************
  // Serializer side of the pair stream
  // ****************************************
  initial tx_ready = 1'b0;
  // Slow mode drops ready at random, like a busy serializer
  always @(negedge clk) begin
    tx_ready <= !stall && (!slow || $random(seed) % 2 == 0);
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beats     <= 0;
      last_pair <= 10'h155;
    end else if (tx_valid && tx_ready) begin
      last_pair <= tx_pair;
      beats     <= beats + 1;
    end
  end
endmodule // phytx_pmd_model

`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import phytx_pkg::*;
  logic       sys_clk = 0, rst_n = 0, cb_stb = 0, cb_we = 0;
  logic [7:0] cb_addr = 0, cb_wdata = 0, cb_rdata, int_cond = 0, rd, m8, ex;
  logic       int_n, wrej_set, cwi_set, trig_fire = 0, stop_mode = 0;
  logic [2:0] trig_mode = 0;
  logic [9:0] req_pair = 0, inj_pair = 0, tx_pair, last_pair, hold;
  logic       req_valid = 0, req_ready, inj_hit = 0, inj_done, tx_valid;
  logic       tx_ready, tx_enable, smooth_en, parity_en, stall = 0, slow = 0;
  int         fail_count = 0, n_compared = 0, seed = 15745, beats;
  int         cwi_cnt = 0, wrej_cnt = 0, done_cnt = 0, c0, w0, d0;

  always #25 sys_clk = ~sys_clk;

  phytx_ctrl dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .CB_STB(cb_stb),
    .CB_WE(cb_we), .CB_ADDR(cb_addr), .CB_WDATA(cb_wdata),
    .CB_RDATA(cb_rdata), .INT_COND(int_cond), .INT_N(int_n),
    .WREJ_SET(wrej_set), .CWI_SET(cwi_set), .TRIG_FIRE(trig_fire),
    .TRIG_MODE(trig_mode), .STOP_MODE(stop_mode), .REQ_PAIR(req_pair),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .INJ_PAIR(inj_pair),
    .INJ_HIT(inj_hit), .INJ_DONE(inj_done), .TX_PAIR(tx_pair),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_ENABLE(tx_enable),
    .SMOOTH_EN(smooth_en), .PARITY_EN(parity_en));

  phytx_pmd_model pmd_u (.clk(sys_clk), .rst_n(rst_n), .tx_pair(tx_pair),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall), .slow(slow),
    .last_pair(last_pair), .beats(beats));

  // Pulses are counted so the exact cycle does not matter
  always @(posedge sys_clk) begin
    if (cwi_set === 1'b1) cwi_cnt++;
    if (wrej_set === 1'b1) wrej_cnt++;
    if (inj_done === 1'b1) done_cnt++;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Extra idle cycle keeps strobe edges apart between accesses
  task automatic bus(input logic we, input logic [7:0] a, d);
    cb_we = we;
    cb_addr = a;
    cb_wdata = d;
    cb_stb = 1;
    @(negedge sys_clk);
    cb_stb = 0;
    rd = cb_rdata;
    @(negedge sys_clk);
  endtask

  // Read first so the compare copy matches the state
  task automatic wr_tsc(input logic [7:0] d);
    bus(0, 8'h04, 8'h00);
    bus(1, 8'h04, d);
  endtask

  function automatic logic [9:0] exp_pair(input logic [2:0] m,
                                          input logic [9:0] req);
    case (m)
      3'b000: return req;
      3'b001: return 10'h3FF;
      3'b100: return 10'h080;
      3'b101: return 10'h084;
      default: return 10'h000;
    endcase
  endfunction

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(negedge sys_clk);
    rst_n = 1;
    bus(0, 8'h03, 8'h00); chk(rd, 10'h000, "mask reset");
    bus(0, 8'h04, 8'h00); chk(rd, 10'h0A2, "state reset");
    chk({parity_en, smooth_en, tx_enable}, 3'b010, "reset outs");
    bus(0, 8'h55, 8'h00); chk(rd, 10'h000, "unmapped read");
    for (int i = 0; i < 24; i++) begin
      m8 = (i < 8) ? (8'h01 << i) : 8'($random(seed));
      int_cond = (i < 8) ? ~m8 : 8'($random(seed));
      bus(1, 8'h03, m8);
      bus(0, 8'h03, 8'h00); chk(rd, m8, "mask rw");
      chk(int_n, !(|(int_cond & m8)), "irq level");
      int_cond = m8;
      repeat (2) @(negedge sys_clk);
      chk(int_n, m8 == 0, "irq bit map");
      bus(1, 8'h03, 8'h00); chk(int_n, 1, "irq masked off");
    end
    req_valid = 1;
    req_pair = 10'($random(seed));
    for (int i = 0; i < 8; i++) begin
      wr_tsc(8'hA0 | 8'(i));
      repeat (10) @(negedge sys_clk);
      chk(last_pair, exp_pair(3'(i), req_pair), "mode pair");
      chk(tx_enable, i != 2, "tx enable");
      bus(0, 8'h04, 8'h00); chk(rd, 8'hA0 | 8'(i), "state rb");
    end
    wr_tsc(8'hC0);
    chk(parity_en, 1, "parity bit");
    chk(smooth_en, 0, "smoother off");
    stop_mode = 1;
    repeat (10) @(negedge sys_clk);
    chk(last_pair, 10'h000, "stop quiet");
    chk(tx_enable, 0, "stop txe");
    stop_mode = 0;
    stall = 1;
    repeat (8) @(negedge sys_clk);
    chk(req_ready, 0, "buffer full");
    hold = tx_pair;
    repeat (3) @(negedge sys_clk);
    chk(tx_pair, hold, "stall hold");
    stall = 0;
    slow = 1;
    repeat (20) @(negedge sys_clk);
    chk(last_pair, req_pair, "drain");
    slow = 0;
    bus(0, 8'h04, 8'h00);
    trig_mode = 3'b101;
    trig_fire = 1;
    @(negedge sys_clk);
    trig_fire = 0;
    c0 = cwi_cnt;
    bus(1, 8'h04, 8'hA3);
    ex = (8'hA3 & ~8'h05) | (8'hC5 & 8'h05);
    bus(0, 8'h04, 8'h00); chk(rd, ex, "cond write");
    chk(cwi_cnt - c0, 1, "inhibit flag");
    w0 = wrej_cnt;
    trig_mode = 3'b110;
    trig_fire = 1;
    bus(1, 8'h04, 8'h00);
    trig_fire = 0;
    ex = (ex & 8'hF8) | 8'h06;
    bus(0, 8'h04, 8'h00); chk(rd, ex, "trigger copy");
    chk(wrej_cnt - w0, 1, "write reject");
    inj_pair = 10'($random(seed));
    wr_tsc(ex | 8'h18);
    repeat (10) @(negedge sys_clk);
    chk(last_pair, inj_pair, "inject wins");
    inj_pair = 10'($random(seed));
    wr_tsc(ex | 8'h10);
    inj_hit = 1;
    repeat (10) @(negedge sys_clk);
    chk(last_pair, inj_pair, "periodic inject");
    inj_hit = 0;
    d0 = done_cnt;
    wr_tsc(ex | 8'h08);
    inj_hit = 1;
    @(negedge sys_clk);
    inj_hit = 0;
    repeat (10) @(negedge sys_clk);
    chk(done_cnt - d0, 1, "one shot done");
    bus(0, 8'h04, 8'h00); chk(rd, ex, "ic low cleared");
    report_and_stop();
  end
endmodule // testbench

`default_nettype wire
